// >>> src/modbus_slave_pkg.sv
package modbus_slave_pkg;

  // ********
  // function codes and exception layout
  // ********
  localparam logic [7:0] FN_READ16   = 8'h03;
  localparam logic [7:0] FN_WRITE16  = 8'h06;
  localparam logic [7:0] FN_DIAG     = 8'h08;
  localparam logic [7:0] FN_READ32   = 8'h64;
  localparam logic [7:0] FN_WRITE32  = 8'h65;
  localparam logic [7:0] EXC_FLAG    = 8'h80;

  localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDRESS  = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_VALUE    = 8'h03;
  localparam logic [7:0] EXC_DEVICE_FAILURE   = 8'h04;

  // ********
  // field values
  // ********
  localparam logic [15:0] SUB_CLEAR_COUNTERS = 16'h000A;
  localparam logic [15:0] SUB_MSG_COUNT      = 16'h000E;
  localparam logic [15:0] REG_COUNT_ONE      = 16'h0001;
  localparam logic [7:0]  BYTE_COUNT_16      = 8'h02;
  localparam logic [3:0]  VOLATILE_SET_OFFSET = 4'h5;
  localparam logic [3:0]  MAX_DATA_SET       = 4'h9;
  localparam int          SET_MSB            = 15;
  localparam int          SET_LSB            = 12;
  localparam int          PARAM_MSB          = 11;

  // ********
  // frame lengths, crc included for requests, excluded for replies
  // ********
  localparam logic [3:0] LEN_MIN     = 4'h4;
  localparam logic [3:0] LEN_READ16  = 4'h8;
  localparam logic [3:0] LEN_WRITE16 = 4'h8;
  localparam logic [3:0] LEN_DIAG    = 4'h8;
  localparam logic [3:0] LEN_READ32  = 4'h6;
  localparam logic [3:0] LEN_WRITE32 = 4'hA;
  localparam logic [3:0] LEN_CRC     = 4'h2;
  localparam logic [3:0] LEN_EXC     = 4'h3;
  localparam logic [3:0] LEN_RSP16   = 4'h5;
  localparam logic [3:0] LEN_RSP32   = 4'h6;
  localparam int         RX_MAX      = 10;
  localparam int         TX_MAX      = 8;

  // ********
  // crc-16, reflected polynomial, residue over a whole good frame
  // ********
  localparam logic [15:0] CRC_INIT    = 16'hFFFF;
  localparam logic [15:0] CRC_POLY    = 16'hA001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;

  // ********
  // timing and buffering
  // ********
  localparam int CLOCK_MHZ          = 100;
  localparam int REPLY_DELAY_US     = 10000;
  localparam int REPLY_DELAY_CYCLES = REPLY_DELAY_US * CLOCK_MHZ;
  localparam int TX_FIFO_DEPTH      = 8;
  localparam int TX_FIFO_WIDTH      = 8;

endpackage : modbus_slave_pkg

// >>> src/crc16_byte_step.sv
`timescale 1ns/100ps
module crc16_byte_step (
  input  wire logic [15:0] i_crc,   // running crc
  input  wire logic [7:0]  i_data,  // next byte
  output logic      [15:0] o_crc    // crc after the byte
);

  // ********
  // eight shifts of the reflected crc, lsb first
  // ********
  always_comb begin
    logic [15:0] acc;
    acc = i_crc ^ {8'h00, i_data};
    for (int b = 0; b < 8; b++) begin
      acc = acc[0] ? ((acc >> 1) ^ modbus_slave_pkg::CRC_POLY) : (acc >> 1);
    end
    o_crc = acc;
  end

endmodule : crc16_byte_step

// >>> src/tx_byte_fifo.sv
`timescale 1ns/100ps
module tx_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clock,     // system clock
  input  wire logic             i_sys_rst,   // synchronous reset
  input  wire logic             i_in_valid,  // write request
  output logic                  o_in_ready,  // room for a word
  input  wire logic [WIDTH-1:0] i_in_data,   // word written
  output logic                  o_out_valid, // word available
  input  wire logic             i_out_ready, // reader takes word
  output logic      [WIDTH-1:0] o_out_data   // oldest word
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count != (PW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // ********
  // storage and pointers
  // ********
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule : tx_byte_fifo

// >>> src/modbus_rtu_param_slave.sv
`timescale 1ns/100ps
// Behaviour
// R1: read16 request: addr, 03, selector, count, crc
// R2: selector: set in top nibble, parameter below
// R3: read16 reply: echo, 02, value, crc
// R4: read16 count not one: exception 83/02
// R5: write16 request: 06, selector, value, crc
// R6: good writes answered by exact echo
// R7: write16 out of range: exception 86/04
// R8: read32: 64, selector; reply four bytes
// R9: read32 unknown parameter: exception E4/04
// R10: write32 request: 65, selector, value, crc
// R11: write32 out of range: exception E5/04
// R12: diag 0A clears counters, echoes request
// R13: diag 0E returns count including this one
// R14: unsupported diag sub-function: exception 88/01
// R15: crc16 low first; bad crc silently dropped
// R16: exception: addr, function|80, code, crc
// R17: sets 5..9 write volatile copy only
// R18: set 0 read fails unless sets equal
// R19: reply no earlier than 10 ms
module modbus_rtu_param_slave #(
  parameter int REPLY_DELAY_CYCLES = modbus_slave_pkg::REPLY_DELAY_CYCLES
) (
  input  wire logic        i_clock,         // 100 MHz system clock
  input  wire logic        i_sys_rst,       // synchronous reset, high
  input  wire logic [7:0]  i_slave_address, // own bus address
  input  wire logic        i_rx_valid,      // received byte strobe
  input  wire logic [7:0]  i_rx_data,       // received byte
  input  wire logic        i_rx_frame_end,  // end of frame strobe
  output logic             o_tx_valid,      // reply byte available
  output logic      [7:0]  o_tx_data,       // reply byte
  input  wire logic        i_tx_ready,      // link takes reply byte
  output logic             o_par_req,       // parameter access pulse
  output logic             o_par_write,     // access is a write
  output logic             o_par_wide,      // 32-bit access
  output logic             o_par_volatile,  // write without commit
  output logic      [3:0]  o_par_data_set,  // data set 0..4
  output logic      [11:0] o_par_number,    // parameter number
  output logic      [31:0] o_par_wdata,     // value written
  input  wire logic        i_par_done,      // access finished pulse
  input  wire logic        i_par_fail,      // range, unknown or sets differ
  input  wire logic [31:0] i_par_rdata      // value read
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_DECODE, ST_PARAM, ST_HOLD, ST_SEND, ST_CRC_LO, ST_CRC_HI
  } state_t;

  state_t      state;
  logic [7:0]  rx_buf [modbus_slave_pkg::RX_MAX];
  logic [3:0]  rx_count;
  logic [3:0]  rx_len;
  logic [15:0] rx_crc;
  logic [15:0] next_rx_crc;
  logic [7:0]  tx_buf [modbus_slave_pkg::TX_MAX];
  logic [3:0]  tx_len;
  logic [3:0]  tx_idx;
  logic [15:0] tx_crc;
  logic [15:0] next_tx_crc;
  logic [15:0] msg_count;
  logic [31:0] delay_left;
  logic        frame_ok;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic [7:0]  fifo_in_data;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic        fifo_out_ready;

  // ********
  // request fields
  // ********
  logic [7:0]  fn;
  logic [15:0] selector;
  logic [15:0] word16;
  logic [31:0] word32;
  logic [3:0]  data_set;

  assign fn       = rx_buf[1];
  // R2: selector split
  assign selector = {rx_buf[2], rx_buf[3]};
  assign word16   = {rx_buf[4], rx_buf[5]};
  assign word32   = {rx_buf[4], rx_buf[5], rx_buf[6], rx_buf[7]};
  assign data_set = selector[modbus_slave_pkg::SET_MSB:modbus_slave_pkg::SET_LSB];

  // ********
  // crc steps for receive and transmit
  // ********
  crc16_byte_step u_rx_crc (
    .i_crc  (rx_crc),
    .i_data (i_rx_data),
    .o_crc  (next_rx_crc)
  );

  crc16_byte_step u_tx_crc (
    .i_crc  (tx_crc),
    .i_data (fifo_in_data),
    .o_crc  (next_tx_crc)
  );

  // ********
  // frame capture
  // ********
  // R15: whole-frame crc residue must be zero
  assign frame_ok = (rx_count >= modbus_slave_pkg::LEN_MIN)
                 && (rx_count <= 4'(modbus_slave_pkg::RX_MAX))
                 && (rx_crc == modbus_slave_pkg::CRC_RESIDUE)
                 && (rx_buf[0] == i_slave_address);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rx_count <= '0;
      rx_crc   <= modbus_slave_pkg::CRC_INIT;
    end else if (state != ST_IDLE || i_rx_frame_end) begin
      rx_count <= '0;
      rx_crc   <= modbus_slave_pkg::CRC_INIT;
    end else if (i_rx_valid) begin
      rx_crc <= next_rx_crc;
      if (rx_count <= 4'(modbus_slave_pkg::RX_MAX)) begin
        rx_count <= rx_count + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (state == ST_IDLE && i_rx_valid && !i_rx_frame_end
        && rx_count < 4'(modbus_slave_pkg::RX_MAX)) begin
      rx_buf[rx_count] <= i_rx_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rx_len <= '0;
    end else if (state == ST_IDLE && i_rx_frame_end) begin
      rx_len <= rx_count;
    end
  end

  // ********
  // slave message counter
  // ********
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      msg_count <= '0;
    end else if (state == ST_DECODE && fn == modbus_slave_pkg::FN_DIAG
                 && rx_len == modbus_slave_pkg::LEN_DIAG
                 && selector == modbus_slave_pkg::SUB_CLEAR_COUNTERS
                 && word16 == 16'h0000) begin
      // R12: clear every counter
      msg_count <= '0;
    end else if (state == ST_IDLE && i_rx_frame_end && frame_ok) begin
      // R13: count includes current request
      msg_count <= msg_count + 16'h0001;
    end
  end

  // ********
  // reply hold-off
  // ********
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      delay_left <= '0;
    end else if (state == ST_IDLE && i_rx_frame_end && frame_ok) begin
      // R19: hold-off starts at frame end
      delay_left <= 32'(REPLY_DELAY_CYCLES);
    end else if (delay_left != '0) begin
      delay_left <= delay_left - 32'h0000_0001;
    end
  end

  // ********
  // sequencer
  // ********
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          // R15: bad or foreign frames get no reply
          if (i_rx_frame_end && frame_ok) begin
            state <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          state <= ST_HOLD;
          unique case (fn)
            // R1: read16 length and count
            modbus_slave_pkg::FN_READ16: begin
              if (rx_len != modbus_slave_pkg::LEN_READ16) begin
                state <= ST_IDLE;
              end else if (word16 == modbus_slave_pkg::REG_COUNT_ONE
                           && data_set <= modbus_slave_pkg::MAX_DATA_SET) begin
                state <= ST_PARAM;
              end
            end
            modbus_slave_pkg::FN_WRITE16: begin
              if (rx_len != modbus_slave_pkg::LEN_WRITE16) begin
                state <= ST_IDLE;
              end else if (data_set <= modbus_slave_pkg::MAX_DATA_SET) begin
                state <= ST_PARAM;
              end
            end
            modbus_slave_pkg::FN_READ32: begin
              if (rx_len != modbus_slave_pkg::LEN_READ32) begin
                state <= ST_IDLE;
              end else if (data_set <= modbus_slave_pkg::MAX_DATA_SET) begin
                state <= ST_PARAM;
              end
            end
            modbus_slave_pkg::FN_WRITE32: begin
              if (rx_len != modbus_slave_pkg::LEN_WRITE32) begin
                state <= ST_IDLE;
              end else if (data_set <= modbus_slave_pkg::MAX_DATA_SET) begin
                state <= ST_PARAM;
              end
            end
            modbus_slave_pkg::FN_DIAG: begin
              if (rx_len != modbus_slave_pkg::LEN_DIAG) begin
                state <= ST_IDLE;
              end
            end
            default: begin
              state <= ST_HOLD;
            end
          endcase
        end
        ST_PARAM: begin
          if (i_par_done) begin
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (delay_left == '0) begin
            state <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (fifo_in_ready && tx_idx == tx_len - 4'h1) begin
            state <= ST_CRC_LO;
          end
        end
        ST_CRC_LO: begin
          if (fifo_in_ready) begin
            state <= ST_CRC_HI;
          end
        end
        ST_CRC_HI: begin
          if (fifo_in_ready) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ********
  // reply frame assembly
  // ********
  task automatic set_exception(input logic [7:0] code);
    tx_buf[1] <= fn | modbus_slave_pkg::EXC_FLAG;
    tx_buf[2] <= code;
    tx_len    <= modbus_slave_pkg::LEN_EXC;
  endtask : set_exception

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      tx_len <= '0;
      for (int i = 0; i < modbus_slave_pkg::TX_MAX; i++) begin
        tx_buf[i] <= 8'h00;
      end
    end else if (state == ST_DECODE) begin
      // R6: default reply is the request without crc
      for (int i = 0; i < modbus_slave_pkg::TX_MAX; i++) begin
        tx_buf[i] <= rx_buf[i];
      end
      tx_len <= rx_len - modbus_slave_pkg::LEN_CRC;
      unique case (fn)
        modbus_slave_pkg::FN_READ16: begin
          // R4: register count must be one
          if (word16 != modbus_slave_pkg::REG_COUNT_ONE
              || data_set > modbus_slave_pkg::MAX_DATA_SET) begin
            set_exception(modbus_slave_pkg::EXC_ILLEGAL_ADDRESS);
          end
        end
        modbus_slave_pkg::FN_WRITE16, modbus_slave_pkg::FN_READ32,
        modbus_slave_pkg::FN_WRITE32: begin
          if (data_set > modbus_slave_pkg::MAX_DATA_SET) begin
            set_exception(modbus_slave_pkg::EXC_ILLEGAL_ADDRESS);
          end
        end
        modbus_slave_pkg::FN_DIAG: begin
          if (selector == modbus_slave_pkg::SUB_CLEAR_COUNTERS) begin
            if (word16 != 16'h0000) begin
              set_exception(modbus_slave_pkg::EXC_ILLEGAL_VALUE);
            end
          end else if (selector == modbus_slave_pkg::SUB_MSG_COUNT) begin
            // R13: counter in data field
            tx_buf[4] <= msg_count[15:8];
            tx_buf[5] <= msg_count[7:0];
          end else begin
            // R14: unsupported sub-function
            set_exception(modbus_slave_pkg::EXC_ILLEGAL_FUNCTION);
          end
        end
        default: begin
          set_exception(modbus_slave_pkg::EXC_ILLEGAL_FUNCTION);
        end
      endcase
    end else if (state == ST_PARAM && i_par_done) begin
      if (i_par_fail) begin
        // R7 R9 R11 R18: store refusal
        set_exception(modbus_slave_pkg::EXC_DEVICE_FAILURE);
      end else if (fn == modbus_slave_pkg::FN_READ16) begin
        // R3: byte count then value high first
        tx_buf[2] <= modbus_slave_pkg::BYTE_COUNT_16;
        tx_buf[3] <= i_par_rdata[15:8];
        tx_buf[4] <= i_par_rdata[7:0];
        tx_len    <= modbus_slave_pkg::LEN_RSP16;
      end else if (fn == modbus_slave_pkg::FN_READ32) begin
        // R8: four bytes msb first, no byte count
        tx_buf[2] <= i_par_rdata[31:24];
        tx_buf[3] <= i_par_rdata[23:16];
        tx_buf[4] <= i_par_rdata[15:8];
        tx_buf[5] <= i_par_rdata[7:0];
        tx_len    <= modbus_slave_pkg::LEN_RSP32;
      end
    end
  end

  // ********
  // parameter store access
  // ********
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_par_req      <= 1'b0;
      o_par_write    <= 1'b0;
      o_par_wide     <= 1'b0;
      o_par_volatile <= 1'b0;
      o_par_data_set <= '0;
      o_par_number   <= '0;
      o_par_wdata    <= '0;
    end else begin
      o_par_req <= 1'b0;
      if (state == ST_DECODE && data_set <= modbus_slave_pkg::MAX_DATA_SET
          && ((fn == modbus_slave_pkg::FN_READ16 && rx_len == modbus_slave_pkg::LEN_READ16
               && word16 == modbus_slave_pkg::REG_COUNT_ONE)
           || (fn == modbus_slave_pkg::FN_WRITE16 && rx_len == modbus_slave_pkg::LEN_WRITE16)
           || (fn == modbus_slave_pkg::FN_READ32 && rx_len == modbus_slave_pkg::LEN_READ32)
           || (fn == modbus_slave_pkg::FN_WRITE32 && rx_len == modbus_slave_pkg::LEN_WRITE32))) begin
        o_par_req <= 1'b1;
        // R5: 16-bit write value
        // R10: 32-bit write value
        o_par_write  <= (fn == modbus_slave_pkg::FN_WRITE16) || (fn == modbus_slave_pkg::FN_WRITE32);
        o_par_wide   <= (fn == modbus_slave_pkg::FN_READ32) || (fn == modbus_slave_pkg::FN_WRITE32);
        o_par_number <= selector[modbus_slave_pkg::PARAM_MSB:0];
        o_par_wdata  <= (fn == modbus_slave_pkg::FN_WRITE32) ? word32 : {16'h0000, word16};
        // R17: high sets map to volatile copy
        o_par_volatile <= data_set >= modbus_slave_pkg::VOLATILE_SET_OFFSET;
        o_par_data_set <= (data_set >= modbus_slave_pkg::VOLATILE_SET_OFFSET)
                        ? data_set - modbus_slave_pkg::VOLATILE_SET_OFFSET : data_set;
      end
    end
  end

  // ********
  // transmit into the fifo
  // ********
  assign fifo_in_valid = (state == ST_SEND) || (state == ST_CRC_LO) || (state == ST_CRC_HI);

  // R15: crc appended low byte first
  // R16: exception frame built above, crc here
  always_comb begin
    unique case (state)
      ST_CRC_LO: fifo_in_data = tx_crc[7:0];
      ST_CRC_HI: fifo_in_data = tx_crc[15:8];
      default:   fifo_in_data = tx_buf[tx_idx[2:0]];
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      tx_idx <= '0;
      tx_crc <= modbus_slave_pkg::CRC_INIT;
    end else if (state == ST_HOLD) begin
      tx_idx <= '0;
      tx_crc <= modbus_slave_pkg::CRC_INIT;
    end else if (state == ST_SEND && fifo_in_ready) begin
      tx_idx <= tx_idx + 4'h1;
      tx_crc <= next_tx_crc;
    end
  end

  tx_byte_fifo #(
    .WIDTH (modbus_slave_pkg::TX_FIFO_WIDTH),
    .DEPTH (modbus_slave_pkg::TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clock     (i_clock),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (fifo_in_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (fifo_in_data),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_out_ready),
    .o_out_data  (fifo_out_data)
  );

  // ********
  // registered output stage
  // ********
  assign fifo_out_ready = !o_tx_valid || i_tx_ready;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_tx_valid <= 1'b0;
      o_tx_data  <= 8'h00;
    end else if (fifo_out_ready) begin
      o_tx_valid <= fifo_out_valid;
      o_tx_data  <= fifo_out_data;
    end
  end

endmodule : modbus_rtu_param_slave

// >>> testbench/modbus_rtu_param_slave_properties.sv
`timescale 1ns/100ps
module modbus_rtu_param_slave_checker #(parameter int REPLY_DELAY_CYCLES = 20) (
  input wire logic        i_clock, i_sys_rst, i_rx_frame_end, i_tx_ready,     // clock, reset, frame end, ready
  input wire logic        o_tx_valid, o_par_req, o_par_write, o_par_wide,     // design outputs
  input wire logic        o_par_volatile,                                     // write without commit
  input wire logic [7:0]  i_slave_address, o_tx_data,                         // own address, reply byte
  input wire logic [3:0]  o_par_data_set,                                     // data set
  input wire logic [31:0] o_par_wdata                                         // write value
);
  logic [31:0] since_end;
  logic        sent_any;
  // ********
  // cycles since frame end, first reply byte marker
  // ********
  always_ff @(posedge i_clock) begin
    since_end <= (i_sys_rst || i_rx_frame_end) ? 32'h0000_0000 : since_end + 32'h0000_0001;
    sent_any  <= (i_sys_rst || i_rx_frame_end) ? 1'b0 : sent_any | o_tx_valid;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  a_reply_not_early: assert property (o_tx_valid |-> since_end >= REPLY_DELAY_CYCLES)
    else $error("reply byte before the reply delay");
  a_tx_byte_held: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("reply byte dropped or changed while stalled");
  a_req_one_pulse: assert property (o_par_req |=> !o_par_req)
    else $error("access request longer than one cycle");
  a_req_after_end: assert property (o_par_req |-> since_end <= 4)
    else $error("access request late after frame end");
  a_set_in_range: assert property (o_par_req |-> o_par_data_set <= 4'h4)
    else $error("data set above four");
  a_fields_with_req: assert property (($changed(o_par_data_set) || $changed(o_par_volatile)) |-> o_par_req)
    else $error("access fields changed without request");
  a_wdata_narrow: assert property (o_par_req && o_par_write && !o_par_wide |-> o_par_wdata[31:16] == 16'h0000)
    else $error("narrow write value not zero extended");
  a_first_is_addr: assert property (o_tx_valid && !sent_any |-> o_tx_data == i_slave_address)
    else $error("reply does not start with own address");
endmodule : modbus_rtu_param_slave_checker
bind modbus_rtu_param_slave modbus_rtu_param_slave_checker #(.REPLY_DELAY_CYCLES(REPLY_DELAY_CYCLES)) u_chk (
  .i_clock, .i_sys_rst, .i_rx_frame_end, .i_tx_ready, .o_tx_valid, .o_par_req, .o_par_write, .o_par_wide,
  .o_par_volatile, .i_slave_address, .o_tx_data, .o_par_data_set, .o_par_wdata);

// >>> testbench/param_store_model.sv
`timescale 1ns/100ps
module param_store_model (
  input  wire logic        i_clock, i_sys_rst, i_par_req, i_par_write, // clock, reset, request, write
  input  wire logic [3:0]  i_par_data_set,                             // data set
  input  wire logic [11:0] i_par_number,                               // parameter number
  input  wire logic [31:0] i_par_wdata,                                // write value
  output logic             o_par_done, o_par_fail,                     // done pulse, refusal
  output logic      [31:0] o_par_rdata                                 // read value
);
  logic [2:0] wait_cnt;
  logic       bad;
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) wait_cnt <= 3'h0;
    else if (i_par_req) wait_cnt <= 3'h4;
    else if (wait_cnt != 3'h0) wait_cnt <= wait_cnt - 3'h1;
  end
  assign o_par_done = (wait_cnt == 3'h1);
  assign bad = (i_par_number == 12'h640) || (!i_par_write && i_par_data_set == 4'h0 && i_par_number == 12'h17A)
    || (i_par_write && (i_par_wdata == 32'h0000_0000 || (i_par_number == 12'h177 && i_par_wdata < 32'h0000_03E8)));
  assign o_par_fail = o_par_done & bad;
  // value only meaningful with done, garbage otherwise
  assign o_par_rdata = o_par_done ? (i_par_number == 12'h174 ? 32'h0000_056E : 32'h0000_03E8) : ~i_par_wdata;
endmodule : param_store_model

// >>> testbench/modbus_rtu_param_slave_test.sv
`timescale 1ns/100ps
module modbus_rtu_param_slave_test;
  typedef logic [7:0] byte_q_t[$];
  localparam int DELAY = 20;
  logic        i_clock = 0, i_sys_rst = 1, i_rx_valid = 0, i_rx_frame_end = 0, i_tx_ready = 0;
  logic [7:0]  i_slave_address = 8'h01, i_rx_data = 8'h00, o_tx_data;
  logic        o_tx_valid, o_par_req, o_par_write, o_par_wide, o_par_volatile, i_par_done, i_par_fail;
  logic [3:0]  o_par_data_set;
  logic [11:0] o_par_number;
  logic [31:0] o_par_wdata, i_par_rdata;
  int          n_fail = 0, n_checks = 0, cycles = 0;
  modbus_rtu_param_slave #(.REPLY_DELAY_CYCLES(DELAY)) u_modbus_rtu_param_slave (.i_clock, .i_sys_rst,
    .i_slave_address, .i_rx_valid, .i_rx_data, .i_rx_frame_end, .o_tx_valid, .o_tx_data, .i_tx_ready, .o_par_req,
    .o_par_write, .o_par_wide, .o_par_volatile, .o_par_data_set, .o_par_number, .o_par_wdata, .i_par_done,
    .i_par_fail, .i_par_rdata);
  param_store_model u_param_store_model (.i_clock, .i_sys_rst, .i_par_req(o_par_req), .i_par_write(o_par_write),
    .i_par_data_set(o_par_data_set), .i_par_number(o_par_number), .i_par_wdata(o_par_wdata),
    .o_par_done(i_par_done), .o_par_fail(i_par_fail), .o_par_rdata(i_par_rdata));
  initial forever #5 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (n_fail == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [15:0] crc16(input byte_q_t q);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction : crc16
  // ********
  // one request frame, reply collected under a toggling ready
  // ********
  task automatic xfer(input byte_q_t rq, input byte_q_t ex, input logic bad);
    logic [15:0] c;
    int          i, w;
    c = crc16(rq);
    rq.push_back(c[7:0] ^ {8{bad}});
    rq.push_back(c[15:8]);
    if (ex.size() > 0) begin
      c = crc16(ex);
      ex.push_back(c[7:0]);
      ex.push_back(c[15:8]);
    end
    foreach (rq[k]) begin
      @(negedge i_clock) i_rx_valid = 1;
      i_rx_data = rq[k];
    end
    @(negedge i_clock) i_rx_valid = 0;
    i_rx_frame_end = 1;
    @(negedge i_clock) i_rx_frame_end = 0;
    i = 0;
    w = 0;
    while (i < ex.size() && w < 500) begin
      @(negedge i_clock) i_tx_ready = ~i_tx_ready;
      w++;
      if (o_tx_valid === 1'b1 && i_tx_ready === 1'b1) begin
        check(o_tx_data, ex[i]);
        i++;
      end
    end
    repeat (DELAY + 40) @(negedge i_clock) if (o_tx_valid !== 1'b0) check(o_tx_valid, 0);
    check(i, ex.size());
    @(negedge i_clock);
  endtask : xfer
  task automatic t_read16();
    xfer('{8'h01, 8'h03, 8'h21, 8'h74, 8'h00, 8'h01}, '{8'h01, 8'h03, 8'h02, 8'h05, 8'h6E}, 0);
    check({o_par_data_set, o_par_number}, 16'h2174);
    xfer('{8'h01, 8'h03, 8'h01, 8'h74, 8'h00, 8'h02}, '{8'h01, 8'h83, 8'h02}, 0);
    xfer('{8'h01, 8'h03, 8'h01, 8'h7A, 8'h00, 8'h01}, '{8'h01, 8'h83, 8'h04}, 0);
  endtask : t_read16
  task automatic t_write16();
    byte_q_t q;
    i_slave_address = 8'h03;
    q = '{8'h03, 8'h06, 8'h41, 8'h78, 8'h00, 8'h0F};
    xfer(q, q, 0);
    check(o_par_wdata, 32'h0000_000F);
    xfer('{8'h03, 8'h06, 8'h21, 8'h78, 8'h00, 8'h00}, '{8'h03, 8'h86, 8'h04}, 0);
    q = '{8'h03, 8'h06, 8'h71, 8'h78, 8'h00, 8'h0F};
    xfer(q, q, 0);
    check({o_par_volatile, o_par_data_set}, 5'h12);
    i_slave_address = 8'h01;
  endtask : t_write16
  task automatic t_wide();
    byte_q_t q;
    xfer('{8'h01, 8'h64, 8'h01, 8'hE1}, '{8'h01, 8'h64, 8'h00, 8'h00, 8'h03, 8'hE8}, 0);
    xfer('{8'h01, 8'h64, 8'h26, 8'h40}, '{8'h01, 8'hE4, 8'h04}, 0);
    q = '{8'h01, 8'h65, 8'h21, 8'h77, 8'h00, 8'h00, 8'h03, 8'hE8};
    xfer(q, q, 0);
    check(o_par_wdata, 32'h0000_03E8);
    xfer('{8'h01, 8'h65, 8'h21, 8'h77, 8'h00, 8'h00, 8'h03, 8'h84}, '{8'h01, 8'hE5, 8'h04}, 0);
  endtask : t_wide
  task automatic t_diag();
    byte_q_t q;
    q = '{8'h01, 8'h08, 8'h00, 8'h0A, 8'h00, 8'h00};
    xfer(q, q, 0);
    xfer('{8'h01, 8'h08, 8'h00, 8'h0E, 8'h00, 8'h00}, '{8'h01, 8'h08, 8'h00, 8'h0E, 8'h00, 8'h01}, 0);
    xfer('{8'h01, 8'h08, 8'h00, 8'h13, 8'h00, 8'h00}, '{8'h01, 8'h88, 8'h01}, 0);
  endtask : t_diag
  task automatic t_drop();
    byte_q_t q;
    q = '{8'h01, 8'h08, 8'h00, 8'h0E, 8'h00, 8'h00};
    xfer(q, '{}, 1);
    i_slave_address = 8'h02;
    xfer(q, '{}, 0);
    i_slave_address = 8'h01;
    xfer(q, '{8'h01, 8'h08, 8'h00, 8'h0E, 8'h00, 8'h03}, 0);
  endtask : t_drop
  initial begin
    repeat (16) @(negedge i_clock);
    i_sys_rst = 0;
    t_read16();
    t_write16();
    t_wide();
    t_diag();
    t_drop();
    finish_test();
  end
endmodule : modbus_rtu_param_slave_test
